// ===== fp_error_signaling_bench.sv
`timescale 1ns/100ps
module fp_error_signaling_bench;
  import fpe_pkg::*;
  logic ref_clk = '0, srst = '1, mode = '0, iv = '0, exc = '0, ack = '0, mw = '0, iov = '0;
  logic [1:0] cls = '0;
  logic [7:0] iop = '0;
  logic [2:0] idx = '0;
  logic [63:0] md = '0;
  logic sw = '0;
  logic [79:0] sd = '0;
  logic [63:0] mr;
  logic go, ft, pend, hlt;
  logic [7:0] fv;
  logic [79:0] sr;
  int n_fail = 0, check_count = 0;
  // Row: mode, class, exception, then fault_take, error_n, halted
  logic [6:0] rows [4] = '{7'h5e, 7'h2a, 7'h72, 7'h19};
  fpe_link_if lk();
  fpe_core i_fpe_core(.ref_clk, .srst, .link(lk.dev), .numeric_error_mode_bit(mode), .insn_valid(iv),
    .insn_class(cls), .insn_fp_exc(exc), .maskable_interrupt_request_ack(ack), .mm_wr(mw), .mm_idx(idx), .mm_wdata(md),
    .st_wr(sw), .st_idx(idx), .st_wdata(sd), .insn_go(go), .fault_take(ft), .fault_vector(fv),
    .exc_pending(pend), .halted(hlt), .st_rdata(sr), .mm_rdata(mr));
  fpe_glue i_fpe_glue(.ref_clk, .srst, .link(lk.glue), .io_wr_valid(iov), .io_wr_port(iop), .ign_latched());
  fpe_fault_assertions i_fpe_fault_assertions(.ref_clk, .srst, .fp_error_out_n(lk.fp_error_out_n),
    .ignore_numeric_err_in_n(lk.ignore_numeric_err_in_n),
    .maskable_interrupt_request(lk.maskable_interrupt_request));
  task automatic chk(logic [79:0] seen, logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Inputs move 1 ns after the edge so the design never races the bench
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #3000;
    n_fail++;
    end_of_test();
  end
  initial begin
    step(4);
    srst = '0;
    step(1);
    chk({lk.fp_error_out_n, lk.ignore_numeric_err_in_n, lk.maskable_interrupt_request, go, hlt}, 5'h18);
    chk(fv, FPE_FAULT_VECTOR);
    foreach (rows[i]) begin
      {mode, cls, exc} = rows[i][6:3];
      iv = '1;
      step(1);
      chk({ft, lk.fp_error_out_n, hlt}, rows[i][2:0]);
      {iv, exc} = '0;
      step(1);
    end
    chk({lk.maskable_interrupt_request, go}, 2'h2);
    {iv, cls, iov, iop} = {3'h4, 1'h1, 8'hf1};
    step(1);
    chk(lk.ignore_numeric_err_in_n, 1'h1);
    iop = FPE_IGN_PORT;
    step(1);
    iov = '0;
    step(1);
    chk(lk.ignore_numeric_err_in_n, 1'h0);
    step(1);
    chk({lk.fp_error_out_n, hlt}, 2'h1);
    cls = 2'h3;
    step(1);
    chk({lk.fp_error_out_n, go, pend, hlt}, 4'hc);
    iv = '0;
    step(1);
    chk({lk.ignore_numeric_err_in_n, lk.maskable_interrupt_request}, 2'h2);
    {iv, cls, exc} = 4'hb;
    step(1);
    chk({hlt, lk.fp_error_out_n, go}, 3'h4);
    {iv, exc, ack} = 3'h1;
    step(1);
    ack = '0;
    step(2);
    chk({hlt, lk.fp_error_out_n, pend}, 3'h3);
    {mw, idx, md} = {1'h1, 3'h5, 64'h0123456789abcdef};
    step(1);
    mw = '0;
    step(1);
    chk(sr, {16'hffff, md});
    chk(mr, md);
    {sw, sd} = {1'h1, 80'h12340011223344556677};
    step(1);
    sw = '0;
    step(1);
    chk(mr, sd[63:0]);
    chk(sr, sd);
    end_of_test();
  end
endmodule : fp_error_signaling_bench

// ===== fpe_core.sv
`timescale 1ns/100ps
// Function
// [RQ1] Mode bit set: vector internally to 10h
// [RQ2] Mode bit clear: external logic raises interrupt
// [RQ3] Assert error output on unmasked exception
// [RQ4] Error asserted, ignore negated: halt, wait
// [RQ5] Glue raises interrupt while error asserted
// [RQ6] Glue sets ignore on write to F0h
// [RQ7] Ignore sampled asserted: drop exception, resume
// [RQ8] Glue holds ignore until error negates
// [RQ9] Multimedia instructions never raise exceptions
// [RQ10] Pending error shows at next sensitive boundary
// [RQ11] Ignore matters only sensitive, mode bit clear
// [RQ12] Multimedia registers alias floating-point stack
// [RQ13] Glue clears ignore latch on reset
module fpe_core
  import fpe_pkg::*;
#(
  parameter int MM_REGS = FPE_MM_REGS,
  parameter int MM_WIDTH = FPE_MM_WIDTH
) (
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  fpe_link_if.dev link, // Glue logic side
  input wire logic numeric_error_mode_bit, // Control register zero mode bit
  input wire logic insn_valid, // Instruction at boundary wants to issue
  input wire logic [1:0] insn_class, // Instruction class at boundary
  input wire logic insn_fp_exc, // Completing fp instruction raised unmasked exception
  input wire logic maskable_interrupt_request_ack, // Interrupt accepted by the sequencer
  input wire logic mm_wr, // Multimedia register write
  input wire logic [FPE_IDX_W-1:0] mm_idx, // Multimedia register index
  input wire logic [MM_WIDTH-1:0] mm_wdata, // Multimedia write data
  input wire logic st_wr, // Fp stack register write
  input wire logic [FPE_IDX_W-1:0] st_idx, // Fp stack register index
  input wire logic [FPE_ST_WIDTH-1:0] st_wdata, // Fp stack write data
  output logic insn_go, // Boundary instruction may issue
  output logic fault_take, // One-cycle internal vector request
  output logic [7:0] fault_vector, // Vector number for fault_take
  output logic exc_pending, // Unmasked exception is pending
  output logic halted, // Execution stopped awaiting interrupt
  output logic [FPE_ST_WIDTH-1:0] st_rdata, // Fp stack read data at st_idx
  output logic [MM_WIDTH-1:0] mm_rdata // Multimedia view of mm_idx
);
  fpe_state_t state_q;
  fpe_state_t state_d;
  logic pend_q;
  logic pend_d;
  logic fp_error_out_n_q;
  logic fp_error_out_n_d;
  logic fault_q;
  logic fault_d;
  logic go_q;
  logic go_d;
  logic halt_q;
  logic halt_d;
  logic [7:0] vec_q;
  logic [FPE_ST_WIDTH-1:0] stack_w [MM_REGS];
  logic [FPE_ST_WIDTH-1:0] st_rd_q;
  logic [MM_WIDTH-1:0] mm_rd_q;

  // Multimedia write image: data in the low bits, exponent field forced to all ones
  function automatic logic [FPE_ST_WIDTH-1:0] mm_image(input logic [MM_WIDTH-1:0] data);
    mm_image = {{(FPE_ST_WIDTH - MM_WIDTH){1'b1}}, data};
  endfunction : mm_image

  // Only fp-class completions raise exceptions; multimedia classes cannot
  wire exc_raise = insn_fp_exc && (insn_class == FPE_CLS_FP); // RQ9 RQ3
  wire sens = insn_valid && fpe_err_sensitive(insn_class); // RQ10
  wire ign_seen = !link.ignore_numeric_err_in_n;
  wire ext_mode = (numeric_error_mode_bit != FPE_MODE_INTERNAL);
  wire hit = sens && (pend_q || exc_raise); // RQ10
  wire ign_ok = ign_seen && ext_mode && sens; // RQ11
  // At most one of these fires on a hit
  wire take_internal = hit && !ext_mode; // RQ1
  wire take_ignore = hit && ign_ok; // RQ7 RQ11
  wire take_stall = hit && ext_mode && !ign_ok; // RQ3 RQ4

  always_comb begin
    state_d = state_q;
    pend_d = pend_q | exc_raise;
    fp_error_out_n_d = fp_error_out_n_q;
    fault_d = 1'b0;
    go_d = insn_valid && !hit;
    unique case (state_q)
      FPE_RUN: begin
        if (take_internal) begin
          fault_d = 1'b1; // RQ1
          pend_d = 1'b0;
        end else if (take_ignore) begin
          pend_d = 1'b0; // RQ7
          go_d = 1'b1;
        end else if (take_stall) begin
          fp_error_out_n_d = 1'b1; // RQ3 RQ10
          state_d = FPE_STALL; // RQ4 RQ2
        end
      end
      FPE_STALL: begin
        // Error output stays low until ignore or an interrupt acknowledge ends the stall
        go_d = 1'b0; // RQ4
        if (ign_ok) begin
          pend_d = 1'b0; // RQ7
          fp_error_out_n_d = 1'b0;
          go_d = 1'b1;
          state_d = FPE_IGNORED;
        end else if (maskable_interrupt_request_ack) begin
          fp_error_out_n_d = 1'b0;
          state_d = FPE_RUN;
        end
      end
      FPE_IGNORED: begin
        // One cycle so glue sees the error output negate before a new stall
        state_d = FPE_RUN;
      end
      default: begin
        // Unused encoding: recover to run with the error output released
        fp_error_out_n_d = 1'b0;
        state_d = FPE_RUN;
      end
    endcase
  end

  assign halt_d = (state_d == FPE_STALL); // RQ4

  // Sync reset only; the storage banks below are left unreset to save area
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= FPE_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= pend_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fp_error_out_n_q <= 1'b0;
    end else begin
      fp_error_out_n_q <= fp_error_out_n_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= halt_d;
    end
  end

  // Vector kept in a flop so the fault port is registered like the others
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      vec_q <= FPE_FAULT_VECTOR;
    end else begin
      vec_q <= FPE_FAULT_VECTOR;
    end
  end

  // One bank per stack entry; a multimedia write wins over an fp write in the same cycle
  for (genvar gi = 0; gi < MM_REGS; gi++) begin : g_entry
    logic [FPE_ST_WIDTH-1:0] entry_q;
    wire mm_sel = mm_wr && (mm_idx == FPE_IDX_W'(gi));
    wire st_sel = st_wr && !mm_wr && (st_idx == FPE_IDX_W'(gi));

    always_ff @(posedge ref_clk) begin
      if (mm_sel) begin
        entry_q <= mm_image(mm_wdata); // RQ12
      end else if (st_sel) begin
        entry_q <= st_wdata;
      end
    end

    assign stack_w[gi] = entry_q; // RQ12
  end

  // Both views read one storage, so saving the fp stack saves the multimedia registers
  // Reads are registered: one cycle from index to data
  always_ff @(posedge ref_clk) begin
    st_rd_q <= stack_w[st_idx];
  end

  always_ff @(posedge ref_clk) begin
    mm_rd_q <= stack_w[mm_idx][MM_WIDTH-1:0]; // RQ12
  end

  assign link.fp_error_out_n = !fp_error_out_n_q; // RQ3
  assign insn_go = go_q;
  assign fault_take = fault_q;
  assign fault_vector = vec_q; // RQ1
  assign exc_pending = pend_q;
  assign halted = halt_q;
  assign st_rdata = st_rd_q;
  assign mm_rdata = mm_rd_q;
endmodule : fpe_core

// ===== fpe_fault_assertions.sv
`timescale 1ns/100ps
module fpe_fault_assertions (
  input wire logic ref_clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic fp_error_out_n, // Error, active low
  input wire logic ignore_numeric_err_in_n, // Ignore, active low
  input wire logic maskable_interrupt_request // Interrupt request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_maskable_interrupt_request; maskable_interrupt_request == !$past(fp_error_out_n); endproperty
  a_maskable_interrupt_request: assert property (p_maskable_interrupt_request) else $error("interrupt not tracking error");
  property p_hold; !fp_error_out_n && !ignore_numeric_err_in_n |=> !ignore_numeric_err_in_n; endproperty
  a_hold: assert property (p_hold) else $error("ignore dropped early");
  property p_rel; $rose(fp_error_out_n) && !ignore_numeric_err_in_n |=> ignore_numeric_err_in_n; endproperty
  a_rel: assert property (p_rel) else $error("ignore not released");
  property p_rst; $past(srst) |-> ignore_numeric_err_in_n && !maskable_interrupt_request; endproperty
  a_rst: assert property (p_rst) else $error("link not idle after reset");
  property p_irq_up; $fell(fp_error_out_n) |=> maskable_interrupt_request; endproperty
  a_irq_up: assert property (p_irq_up) else $error("interrupt not raised after error");
  property p_irq_down; $rose(fp_error_out_n) |=> !maskable_interrupt_request; endproperty
  a_irq_down: assert property (p_irq_down) else $error("interrupt not dropped after error");
  c_stall: cover property ($fell(fp_error_out_n));
  c_ign: cover property ($fell(ignore_numeric_err_in_n));
  c_rel: cover property ($rose(fp_error_out_n));
endmodule : fpe_fault_assertions

// ===== fpe_glue.sv
`timescale 1ns/100ps
module fpe_glue
  import fpe_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic srst, // Synchronous reset, active high
  fpe_link_if.glue link, // Processor side
  input wire logic io_wr_valid, // One-cycle I/O write strobe
  input wire logic [7:0] io_wr_port, // I/O write port address
  output logic ign_latched // Ignore-error latch state
);
  logic ign_q;
  logic ign_d;
  logic irq_q;
  wire port_hit = io_wr_valid && (io_wr_port == FPE_IGN_PORT); // RQ6
  wire err_active = !link.fp_error_out_n;

  // Latch drops as soon as the error is gone, so a stale latch never masks the next error
  assign ign_d = port_hit ? 1'b1 : (err_active ? ign_q : 1'b0); // RQ6 RQ8

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ign_q <= 1'b0; // RQ13
      irq_q <= 1'b0;
    end else begin
      ign_q <= ign_d;
      irq_q <= err_active; // RQ5 RQ2
    end
  end

  assign link.ignore_numeric_err_in_n = !ign_q;
  assign link.maskable_interrupt_request = irq_q;
  assign ign_latched = ign_q;
endmodule : fpe_glue

// ===== fpe_link_if.sv
`timescale 1ns/100ps
interface fpe_link_if;
  logic fp_error_out_n;
  logic ignore_numeric_err_in_n;
  logic maskable_interrupt_request;

  modport dev (
    output fp_error_out_n,
    input ignore_numeric_err_in_n,
    input maskable_interrupt_request
  );
  modport glue (
    input fp_error_out_n,
    output ignore_numeric_err_in_n,
    output maskable_interrupt_request
  );
endinterface : fpe_link_if

// ===== fpe_pkg.sv
package fpe_pkg;
  localparam logic [7:0] FPE_IGN_PORT = 8'hf0;
  localparam logic [7:0] FPE_FAULT_VECTOR = 8'h10;
  localparam int FPE_MM_REGS = 8;
  localparam int FPE_MM_WIDTH = 64;
  localparam int FPE_ST_WIDTH = 80;
  localparam int FPE_IDX_W = 3;
  localparam logic [1:0] FPE_CLS_OTHER = 2'h0;
  localparam logic [1:0] FPE_CLS_FP = 2'h1;
  localparam logic [1:0] FPE_CLS_MM = 2'h2;
  localparam logic [1:0] FPE_CLS_WAIT = 2'h3;
  localparam logic FPE_MODE_INTERNAL = 1'b1;

  typedef enum logic [1:0] {
    FPE_RUN,
    FPE_STALL,
    FPE_IGNORED
  } fpe_state_t;

  function automatic logic fpe_err_sensitive(input logic [1:0] cls);
    fpe_err_sensitive = (cls != FPE_CLS_OTHER);
  endfunction : fpe_err_sensitive
endpackage : fpe_pkg
